// >>> rtl/fts_pkg.sv
/*
 * Constants and carrier types for the flow-through late-write burst SRAM core.
 * Assumes a single 25 MHz clock and no software-visible registers.
 */
package fts_pkg;

   // Array organisation, built as the 36-bit configuration
   localparam int ADDR_W    = 20;
   localparam int WORDS     = 1048576;
   localparam int DATA_W    = 36;
   localparam int LANES     = 4;
   localparam int LANE_W    = 9;
   localparam int LOW_W     = 2;

   // Reset values
   localparam logic [LOW_W-1:0]  CNT_RST   = 2'h0;
   localparam logic [DATA_W-1:0] DATA_RST  = 36'h0_0000_0000;
   localparam logic [LANES-1:0]  LANE_RST  = 4'hF;
   localparam logic [ADDR_W-1:0] ADDR_RST  = 20'h0_0000;
   // Pin synchroniser reset: bit 1 sleep request, bit 0 burst order (pulled high)
   localparam logic [1:0]        PIN_RST   = 2'h1;
   localparam int                PIN_SLEEP = 1;
   localparam int                PIN_ORDER = 0;

   // Operation held by the burst engine
   typedef enum logic [1:0] {
      FTS_IDLE,
      FTS_READ,
      FTS_WRITE
   } fts_op_e;

   // Burst engine state
   typedef struct packed {
      fts_op_e           op;
      logic [ADDR_W-1:0] base;
      logic [LOW_W-1:0]  cnt;
   } fts_burst_s;

   // Write waiting for its late data
   typedef struct packed {
      logic              pend;
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0]  lane_n;
   } fts_wr_s;

endpackage

// >>> rtl/fts_sram_core.sv
/*
 * Flow-through burst SRAM core with late write: read data follows the command
 * by one cycle, write data follows its command by one cycle, so any mix of
 * reads and writes runs with no dead cycle.
 * Holds the word array, the burst engine, the late-write pipeline and the
 * data pin drive; built in the 36-bit width only.
 * Assumes the master drives every synchronous input from clock_in; the sleep
 * and burst order pins are asynchronous and pass a synchroniser here.
 * Assumes the data pins are split into input, output and active-low enable,
 * with the tri-state buffer itself outside this block.
 * The array is not reset: a read of a word never written returns unknowns.
 * Sleep and burst order act four to five edges after their pins change.
 */
`timescale 1ns/1ps

module fts_sram_core (
   // Clock and reset
   input  wire logic                        clock_in,
   input  wire logic                        sys_rst_in,
   // Synchronous command
   input  wire logic                        clock_gate_n_in,
   input  wire logic                        burst_step_or_load_in,
   input  wire logic                        rw_select_in,
   input  wire logic [fts_pkg::LANES-1:0]   byte_lane_write_n_in,
   input  wire logic                        chip_select_low_a_n_in,
   input  wire logic                        chip_select_high_in,
   input  wire logic                        chip_select_low_b_n_in,
   input  wire logic [fts_pkg::ADDR_W-1:0]  addr_in,
   // Asynchronous controls
   input  wire logic                        output_enable_n_in,
   input  wire logic                        burst_order_select_in,
   input  wire logic                        sleep_request_in,
   // Data pins, split into three signals
   input  wire logic [fts_pkg::DATA_W-1:0]  dq_in,
   output logic      [fts_pkg::DATA_W-1:0]  dq_out,
   output logic                             dq_oe_n_out
);

   logic [fts_pkg::DATA_W-1:0] mem_array [fts_pkg::WORDS];

   fts_pkg::fts_burst_s        burst_reg;
   fts_pkg::fts_burst_s        burst_next;
   fts_pkg::fts_wr_s           wr_reg;
   fts_pkg::fts_wr_s           wr_next;
   logic                       rd_valid_reg;
   logic [fts_pkg::DATA_W-1:0] rd_data_reg;
   logic [1:0]                 pin_s1_reg;
   logic [1:0]                 pin_s2_reg;
   logic [1:0]                 pin_s3_reg;
   logic [1:0]                 pin_reg;

   wire                        run_w;
   wire                        sleep_w;
   wire                        order_w;
   wire                        load_w;
   wire                        sel_w;
   wire [fts_pkg::LOW_W-1:0]   step_cnt_w;
   wire [fts_pkg::LOW_W-1:0]   low_w;
   wire [fts_pkg::ADDR_W-1:0]  burst_addr_w;
   wire [fts_pkg::ADDR_W-1:0]  acc_addr_w;
   wire                        is_read_w;
   wire                        is_write_w;
   wire                        ld_read_w;
   wire                        ld_write_w;
   wire                        burst_read_w;
   wire                        burst_write_w;
   wire                        wr_commit_w;
   wire                        same_word_w;
   wire [fts_pkg::LANES-1:0]   fwd_lane_w;

   // Async pins: four flops, a change counts once stages two and three agree
   // The last flop moves only on agreement, so a single odd sample is filtered
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         pin_s1_reg <= fts_pkg::PIN_RST;
         pin_s2_reg <= fts_pkg::PIN_RST;
         pin_s3_reg <= fts_pkg::PIN_RST;
         pin_reg    <= fts_pkg::PIN_RST;
      end else begin
         pin_s1_reg <= {sleep_request_in, burst_order_select_in};
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         for (int i = 0; i < 2; i++) begin
            if (pin_s2_reg[i] == pin_s3_reg[i]) begin
               pin_reg[i] <= pin_s3_reg[i];
            end
         end
      end
   end

   assign sleep_w = pin_reg[fts_pkg::PIN_SLEEP];
   assign order_w = pin_reg[fts_pkg::PIN_ORDER];

   // Command decode; a high clock gate stalls the whole engine
   assign run_w  = !clock_gate_n_in;
   assign load_w = !burst_step_or_load_in;
   assign sel_w  = !chip_select_low_a_n_in && chip_select_high_in
                   && !chip_select_low_b_n_in;

   // Burst address: counter steps, high address bits stay put
   // No carry leaves the low bits, so a burst wraps inside its group of four
   assign step_cnt_w   = fts_pkg::LOW_W'(burst_reg.cnt + 1'b1);
   assign low_w        = order_w ? (burst_reg.base[1:0] ^ step_cnt_w)
                                 : fts_pkg::LOW_W'(burst_reg.base[1:0] + step_cnt_w);
   assign burst_addr_w = {burst_reg.base[fts_pkg::ADDR_W-1:fts_pkg::LOW_W], low_w};
   assign acc_addr_w   = load_w ? addr_in : burst_addr_w;

   // Load decode: a selected load starts a read or a write
   assign ld_read_w     = sel_w && rw_select_in;
   assign ld_write_w    = sel_w && !rw_select_in;
   // Advance decode: the held operation continues at the next burst address
   assign burst_read_w  = (burst_reg.op == fts_pkg::FTS_READ);
   assign burst_write_w = (burst_reg.op == fts_pkg::FTS_WRITE);

   // Access this edge: load takes the pins, advance ignores them; sleep
   // turns every command into a deselect
   assign is_read_w  = !sleep_w && (load_w ? ld_read_w : burst_read_w);
   assign is_write_w = !sleep_w && (load_w ? ld_write_w : burst_write_w);

   // Next burst state and pending write
   // Sleep forces idle so that no burst resumes by itself on wake
   always_comb begin
      burst_next = burst_reg;
      if (sleep_w) begin
         burst_next.op = fts_pkg::FTS_IDLE;
      end else if (load_w) begin
         burst_next.base = addr_in;
         burst_next.cnt  = fts_pkg::CNT_RST;
         if (!sel_w) begin
            burst_next.op = fts_pkg::FTS_IDLE;
         end else if (rw_select_in) begin
            burst_next.op = fts_pkg::FTS_READ;
         end else begin
            burst_next.op = fts_pkg::FTS_WRITE;
         end
      end else if (burst_reg.op != fts_pkg::FTS_IDLE) begin
         burst_next.cnt = step_cnt_w;
      end
      wr_next.pend   = is_write_w;
      wr_next.addr   = acc_addr_w;
      wr_next.lane_n = byte_lane_write_n_in;
   end

   // Control state, held whole while the clock gate is high
   // A frozen edge keeps the counter, the pending write and the read flag
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         burst_reg.op   <= fts_pkg::FTS_IDLE;
         burst_reg.base <= fts_pkg::ADDR_RST;
         burst_reg.cnt  <= fts_pkg::CNT_RST;
         wr_reg.pend    <= 1'b0;
         wr_reg.addr    <= fts_pkg::ADDR_RST;
         wr_reg.lane_n  <= fts_pkg::LANE_RST;
         rd_valid_reg <= 1'b0;
      end else if (run_w) begin
         burst_reg    <= burst_next;
         wr_reg       <= wr_next;
         rd_valid_reg <= is_read_w;
      end
   end

   // Late data lands only on an edge that the clock gate lets through and
   // only while awake; a write caught by sleep is dropped, not deferred
   assign wr_commit_w = run_w && wr_reg.pend && !sleep_w;
   // A read of the word whose late data lands this edge takes those lanes
   // straight from the data pins, since the array still holds the old word
   assign same_word_w = wr_reg.pend && (wr_reg.addr == acc_addr_w);
   assign fwd_lane_w  = same_word_w ? ~wr_reg.lane_n : '0;

   // Array: late write data lands one edge after its command; a read of
   // the word being written this edge is forwarded lane by lane, so a
   // write followed at once by a read of the same word needs no gap.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         rd_data_reg <= fts_pkg::DATA_RST;
      end else if (run_w) begin
         if (wr_commit_w) begin
            for (int i = 0; i < fts_pkg::LANES; i++) begin
               if (!wr_reg.lane_n[i]) begin
                  mem_array[wr_reg.addr][i*fts_pkg::LANE_W +: fts_pkg::LANE_W]
                     <= dq_in[i*fts_pkg::LANE_W +: fts_pkg::LANE_W];
               end
            end
         end
         if (is_read_w) begin
            rd_data_reg <= mem_array[acc_addr_w];
            for (int i = 0; i < fts_pkg::LANES; i++) begin
               if (fwd_lane_w[i]) begin
                  rd_data_reg[i*fts_pkg::LANE_W +: fts_pkg::LANE_W]
                     <= dq_in[i*fts_pkg::LANE_W +: fts_pkg::LANE_W];
               end
            end
         end
      end
   end

   // Pin drive: only a read output cycle, output enable low, not asleep.
   // Write data cycles have rd_valid_reg low, so the bus turns with no gap
   // even with the output enable held low throughout.
   assign dq_out      = rd_data_reg;
   assign dq_oe_n_out = !(rd_valid_reg && !output_enable_n_in && !sleep_w);
   // The output enable never enters the write path above, so it may be held
   // low for good; only the read flag and sleep decide who owns the data lines

endmodule // fts_sram_core

// >>> bench/fts_sram_properties.sv
/* Port checker for the SRAM core.
   Bound to every fts_sram_core; sees its ports only. */
`timescale 1ns/1ps
module fts_sram_properties (
   // Clock and reset
   input  wire logic                       clock_in,
   input  wire logic                       sys_rst_in,
   // Synchronous command
   input  wire logic                       clock_gate_n_in,
   input  wire logic                       burst_step_or_load_in,
   input  wire logic                       rw_select_in,
   input  wire logic                       chip_select_low_a_n_in,
   input  wire logic                       chip_select_high_in,
   input  wire logic                       chip_select_low_b_n_in,
   // Asynchronous pins
   input  wire logic                       output_enable_n_in,
   input  wire logic                       sleep_request_in,
   // Watched design outputs
   input  wire logic                       dq_oe_n_out,
   input  wire logic [fts_pkg::DATA_W-1:0] dq_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   // Edge decode; raw sleep suffices since sleep only adds refusals
   wire go = !clock_gate_n_in && !sleep_request_in;
   wire sel = !chip_select_low_a_n_in && chip_select_high_in && !chip_select_low_b_n_in;
   wire ld = go && !burst_step_or_load_in;
   wire burst_step_input = go && burst_step_or_load_in;
   wire oe = !output_enable_n_in;
   // Five quiet samples cover the sleep synchroniser lag
   sequence awake; !sleep_request_in [*5]; endsequence
   sequence rd_ld; ld && sel && rw_select_in; endsequence
   sequence desel; ld && !sel; endsequence
   a_desel_floats: assert property (desel |=> dq_oe_n_out)
      else $error("deselect drives");
   a_read_drives: assert property (awake ##0 rd_ld ##1 oe |-> !dq_oe_n_out)
      else $error("read idle");
   a_oe_gates: assert property (output_enable_n_in |-> dq_oe_n_out)
      else $error("oe ignored");
   a_write_floats: assert property (ld && sel && !rw_select_in |=> dq_oe_n_out)
      else $error("write drives");
   a_freeze_holds: assert property (awake ##0 clock_gate_n_in |=> $stable(dq_out))
      else $error("freeze moved");
   a_idle_continues: assert property (desel ##1 burst_step_input |=> dq_oe_n_out)
      else $error("idle burst drives");
   a_burst_reads: assert property (awake ##0 rd_ld ##1 burst_step_input ##1 oe |-> !dq_oe_n_out)
      else $error("burst idle");
   a_sleep_floats: assert property (sleep_request_in [*5] |-> dq_oe_n_out)
      else $error("sleep drives");
endmodule // fts_sram_properties
bind fts_sram_core fts_sram_properties u_props (
   .clock_in               (clock_in),
   .sys_rst_in             (sys_rst_in),
   .clock_gate_n_in        (clock_gate_n_in),
   .burst_step_or_load_in  (burst_step_or_load_in),
   .rw_select_in           (rw_select_in),
   .chip_select_low_a_n_in (chip_select_low_a_n_in),
   .chip_select_high_in    (chip_select_high_in),
   .chip_select_low_b_n_in (chip_select_low_b_n_in),
   .output_enable_n_in     (output_enable_n_in),
   .sleep_request_in       (sleep_request_in),
   .dq_oe_n_out            (dq_oe_n_out),
   .dq_out                 (dq_out)
);

// >>> bench/fts_master_model.sv
/* Master-side data driver for late write data.
   Assumes the bench flags a write in the call that gives its command. */
`timescale 1ns/1ps
module fts_master_model (
   // Clock and request
   input  wire logic        clock_in,
   input  wire logic        wr_valid_in,
   input  wire logic [35:0] wr_data_in,
   // Data lines to the core
   output logic      [35:0] dq_out = '0
);
   // Data lands one edge after the command; released lines invert each cycle
   always @(posedge clock_in) begin
      dq_out <= #1 wr_valid_in ? wr_data_in : ~dq_out;
   end
endmodule // fts_master_model

// >>> bench/tb_fts_sram_core.sv
/* Self-checking bench for the SRAM core.
   Assumes the master model supplies late write data. */
`timescale 1ns/1ps
module tb_fts_sram_core;
   // Bench-driven pins
   logic clk = 0, rst = 1, gn = 0, burst_step_input = 0, rw = 1, oe_n = 0, ord = 1, slp = 0, wv = 0;
   logic [2:0] cs = 3'h0;
   logic [3:0] bw = 4'hF;
   logic [19:0] ad = 20'h0_0000;
   logic [35:0] wd = '0, dq_in, dq_out;
   logic dq_oe_n;
   int bad_count = 0, checked = 0;
   initial forever #20 clk = ~clk;
   fts_master_model mm (.clock_in(clk), .wr_valid_in(wv), .wr_data_in(wd), .dq_out(dq_in));
   fts_sram_core uut (.clock_in(clk), .sys_rst_in(rst), .clock_gate_n_in(gn), .burst_step_or_load_in(burst_step_input),
      .rw_select_in(rw), .byte_lane_write_n_in(bw), .chip_select_low_a_n_in(cs[2]),
      .chip_select_high_in(cs[1]), .chip_select_low_b_n_in(cs[0]), .addr_in(ad),
      .output_enable_n_in(oe_n), .burst_order_select_in(ord), .sleep_request_in(slp),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n_out(dq_oe_n));
   // One command per edge, always 1 ns after it
   task c(input logic l, r, input logic [2:0] s, input logic [19:0] x, input logic g, v,
          input logic [3:0] w, input logic [35:0] d);
      @(posedge clk) #1;
      {burst_step_input, rw, cs, ad, gn, wv, bw, wd} = {l, r, s, x, g, v, w, d};
   endtask
   task wr(input logic [19:0] x, input logic [35:0] d, input logic [3:0] w); c(0, 0, 3'h2, x, 0, 1, w, d); endtask
   task rd(input logic [19:0] x); c(0, 1, 3'h2, x, 0, 0, 4'hF, '0); endtask
   task nop; c(0, 1, 3'h0, 20'h0_0000, 0, 0, 4'hF, '0); endtask
   function logic [35:0] dat(input logic [19:0] x); return {16'hA5C3, x}; endfunction
   // Compare, count, report at once
   task chk(input logic [35:0] got, exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Burst write then burst read from offset 1 with one frozen edge inside
   task t_burst(input logic o);
      logic [19:0] b;
      int e;
      b = o ? 20'h0_0100 : 20'h0_0200;
      ord = o;
      repeat (5) nop;
      wr(b, dat(b), 4'h0);
      for (int k = 1; k < 4; k++) c(1, 1, 3'h0, 20'hF_FFFF, 0, 1, 4'h0, dat(b | 20'(k)));
      rd(b | 20'h0_0001);
      for (int k = 0; k < 5; k++) begin
         e = k - (k > 1);
         c(k < 4, 0, 3'h0, 20'h0_0000, k == 1, 0, 4'h0, '0);
         chk(dq_out, dat(b | 20'(o ? 1 ^ e : (1 + e) % 4)));
      end
      $display("burst test done");
   endtask
   // Partial write straight into a read of the same word
   task t_lanes;
      wr(20'h0_0100, ~dat(20'h0_0100), 4'hA);
      rd(20'h0_0100);
      nop;
      chk(dq_out, (~dat(20'h0_0100) & 36'h0_07FC_01FF) | (dat(20'h0_0100) & ~36'h0_07FC_01FF));
      $display("lane test done");
   endtask
   // Each select alone ends a driving read; an advance with live pins stays idle
   task t_desel;
      for (int i = 0; i < 3; i++) begin
         rd(20'h0_0100);
         c(0, 1, 3'h2 ^ (3'h1 << i), 20'h0_0100, 0, 0, 4'hF, '0);
         chk(36'(dq_oe_n), 36'h0);
         c(1, 1, 3'h2, 20'h0_0100, 0, 0, 4'hF, '0);
         chk(36'(dq_oe_n), 36'h1);
         nop;
         chk(36'(dq_oe_n), 36'h1);
      end
      $display("deselect test done");
   endtask
   // Top word, then the output enable toggled while the read stands
   task t_oe;
      wr(20'hF_FFFF, dat(20'hF_FFFF), 4'h0);
      rd(20'hF_FFFF);
      oe_n = 1;
      nop;
      chk(36'(dq_oe_n), 36'h1);
      oe_n = 0;
      #1 chk(dq_out, dat(20'hF_FFFF));
      chk(36'(dq_oe_n), 36'h0);
      $display("oe test done");
   endtask
   // Reads refused while asleep; contents survive
   task t_sleep;
      nop;
      slp = 1;
      repeat (6) rd(20'h0_0101);
      chk(36'(dq_oe_n), 36'h1);
      slp = 0;
      repeat (6) nop;
      rd(20'h0_0203);
      nop;
      chk(dq_out, dat(20'h0_0203));
      chk(36'(dq_oe_n), 36'h0);
      $display("sleep test done");
   endtask
   task final_report;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Main sequence after 12 reset cycles
   initial begin
      repeat (12) @(posedge clk);
      #1 rst = 0;
      t_burst(1);
      t_burst(0);
      t_lanes;
      t_desel;
      t_oe;
      t_sleep;
      final_report;
   end
   // Watchdog, well past the roughly 3 us the tests need
   initial begin
      #20000;
      bad_count++;
      final_report;
   end
endmodule // tb_fts_sram_core
